// [spdb_pkg.sv]
// constants and types of the serial port data buffer block
`default_nettype none
package spdb_pkg;
  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [3:0] IDX_RXL   = 4'h0;
  localparam logic [3:0] IDX_RXH   = 4'h1;
  localparam logic [3:0] IDX_TXL   = 4'h2;
  localparam logic [3:0] IDX_TXH   = 4'h3;
  localparam logic [3:0] IDX_STAT  = 4'h4;
  localparam logic [3:0] IDX_IRQ_AND_LINE_CTRL = 4'h5;
  localparam logic [3:0] IDX_RX_TX_ENABLE_CTRL = 4'h6;
  localparam logic [3:0] IDX_FRAME_FORMAT_CTRL = 4'h7;
  localparam logic [3:0] IDX_BAUD  = 4'h8;
  localparam logic [3:0] IDX_DBG   = 4'hB;
  localparam logic [3:0] IDX_EV    = 4'hC;
  localparam logic [3:0] IDX_TXPL  = 4'hD;
  localparam logic [3:0] IDX_RXPL  = 4'hE;
  localparam int         ADDR_LSB  = 2;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int RXEN_BIT  = 7;
  localparam int TXEN_BIT  = 6;
  localparam int RXMODE_LO = 1;
  localparam int PMODE_LO  = 4;
  localparam int CMODE_LO  = 6;
  localparam int RXC_BIT   = 7;
  localparam int OVF_BIT   = 6;
  localparam int DRE_BIT   = 5;
  localparam int FRAME_ERROR_FLAG_BIT  = 2;
  localparam int PARITY_ERROR_FLAG_BIT  = 1;
  localparam int D8_BIT    = 0;
  // ************************************************************
  // encodings and reset values
  // ************************************************************
  localparam logic [2:0] CH_5   = 3'h0;
  localparam logic [2:0] CH_6   = 3'h1;
  localparam logic [2:0] CH_7   = 3'h2;
  localparam logic [2:0] CH_9L  = 3'h6;
  localparam logic [2:0] CH_9H  = 3'h7;
  localparam logic [1:0] RXM_LIN = 2'h3;
  localparam logic [1:0] CM_SPI  = 2'h3;
  localparam logic [1:0] PM_OFF  = 2'h0;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RXQ_DEPTH = 2'h2;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [8:0] data;
    logic       stop1;
    logic       parity_error_flag;
    logic       pid;
  } spdb_rx_in_type;
  typedef struct packed {
    logic [8:0] data;
    logic       frame_error_flag;
    logic       parity_error_flag;
    logic       pid;
    logic       ovf;
  } spdb_rx_ent_type;
  typedef struct packed {
    logic [7:0]  irq_and_line_ctrl;
    logic [7:0]  rx_tx_enable_ctrl;
    logic [7:0]  frame_format_ctrl;
    logic [15:0] baud;
    logic        dbgrun;
    logic        evin;
    logic [7:0]  txpl;
    logic [6:0]  rxpl;
  } spdb_cfg_type;
endpackage : spdb_pkg
`default_nettype wire

// [spdb_top.sv]
// serial port data buffers with an AXI4-Lite register slave
// Operation
// R1: two-entry receive queue, flags per entry
// R2: low byte read pops oldest character
// R3: software reads high byte before low
// R4: receive-complete shows unread data; disable flushes
// R5: overflow when full, waiting character, start
// R6: error flags follow queue head until popped
// R7: frame error from first stop bit only
// R8: parity error only with checking enabled
// R9: LIN mode parity flag covers identifier
// R10: LIN mode bit 0 marks response space
// R11: bit 0 holds ninth data bit
// R12: unused upper bits ignored and zeroed
// R13: transmit write accepted only while empty
// R14: holding register moves to empty shifter; code passes the old hold_r value when the shifter is ready at once
// R15: software writes ninth bit before low
// R16: sync host mode ignores ninth, error flags (code drops only the transmit ninth; received ninth still reads in bit 0)
// R17: data registers reset to zero
// R18: empty flag set at reset, cleared on write
// R19: empty-queue read changes nothing
//
// Implementation choice: the AXI4-Lite slave port.
`default_nettype none
module spdb_top
  import spdb_pkg::*;
#(
  parameter int AW = 6
) (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // axi write address and data
  input  wire logic [AW-1:0]  awaddr,
  input  wire logic           awvalid,
  output logic                awready,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  input  wire logic           wvalid,
  output logic                wready,
  // axi write response
  output logic                bvalid,
  output logic [1:0]          bresp,
  input  wire logic           bready,
  // axi read
  input  wire logic [AW-1:0]  araddr,
  input  wire logic           arvalid,
  output logic                arready,
  output logic [31:0]         rdata,
  output logic [1:0]          rresp,
  output logic                rvalid,
  input  wire logic           rready,
  // characters from the receive shifter
  input  wire spdb_rx_in_type rx_in,
  input  wire logic           rx_in_valid,
  output logic                rx_in_ready,
  input  wire logic           rx_start,
  // characters to the transmit shifter
  output logic [8:0]          tx_out_data,
  output logic                tx_out_valid,
  input  wire logic           tx_out_ready,
  // configuration to the rest of the port
  output spdb_cfg_type        cfg
);
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [8:0] size_mask(input logic [8:0] d,
                                           input logic [2:0] cs);
    logic [8:0] m;
    m = 9'h0FF;
    case (cs)
      CH_5:    m = 9'h01F;
      CH_6:    m = 9'h03F;
      CH_7:    m = 9'h07F;
      CH_9L,
      CH_9H:   m = 9'h1FF;
      default: m = 9'h0FF;
    endcase
    return d & m;
  endfunction : size_mask

  function automatic logic mapped(input logic [3:0] idx);
    logic ok;
    ok = 1'b1;
    case (idx)
      4'h9, 4'hA, 4'hF: ok = 1'b0;
      default:          ok = 1'b1;
    endcase
    return ok;
  endfunction : mapped

  // ************************************************************
  // state
  // ************************************************************
  spdb_rx_ent_type q_r [2];
  logic [1:0]      cnt_r;
  logic [1:0]      cnt_nxt;
  logic            ovf_pend_r;
  logic [7:0]      hold_r;
  logic            tx_d8_r;
  logic            tx_empty_r;
  logic            tx_empty_nxt;
  logic [AW-1:0]   awaddr_r;
  logic [31:0]     wdata_r;
  logic [3:0]      wstrb_r;
  logic            rxen;
  logic            txen;
  logic            lin;
  logic            spi;
  logic            pen;
  logic [2:0]      character_size_field;
  logic            push;
  logic            pop;
  logic            rd_go;
  logic [3:0]      rd_idx;
  logic            wr_go;
  logic [3:0]      wr_idx;
  logic            wr_b0;
  logic            wr_b1;
  logic            tx_acc;
  logic            tx_move;
  logic            ovf_set;
  logic [7:0]      rxh;
  logic [31:0]     rd_word;
  spdb_rx_ent_type new_ent;

  assign rxen   = cfg.rx_tx_enable_ctrl[RXEN_BIT];
  assign txen   = cfg.rx_tx_enable_ctrl[TXEN_BIT];
  assign lin    = cfg.rx_tx_enable_ctrl[RXMODE_LO+:2] == RXM_LIN;
  assign spi    = cfg.frame_format_ctrl[CMODE_LO+:2] == CM_SPI;
  assign pen    = cfg.frame_format_ctrl[PMODE_LO+:2] != PM_OFF;
  assign character_size_field = cfg.frame_format_ctrl[2:0];

  // ************************************************************
  // bus decode
  // ************************************************************
  always_comb begin
    wr_go  = !awready && !wready && !bvalid;
    wr_idx = awaddr_r[ADDR_LSB+:4];
    wr_b0  = wr_go && wstrb_r[0];
    wr_b1  = wr_go && wstrb_r[1];
    tx_acc = wr_b0 && wr_idx == IDX_TXL && tx_empty_r; // see R13
    rd_go  = arvalid && arready;
    rd_idx = araddr[ADDR_LSB+:4];
    pop    = rd_go && rd_idx == IDX_RXL && cnt_r != 2'h0; // see R2 R19
    push   = rx_in_valid && rx_in_ready && rxen;
    tx_move = tx_out_valid && tx_out_ready; // see R14
  end

  // ************************************************************
  // write channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      awaddr_r <= '0;
    end else if (awvalid && awready) begin
      awready  <= 1'b0;
      awaddr_r <= awaddr;
    end else if (wr_go) begin
      awready  <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wvalid && wready) begin
      wready  <= 1'b0;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (wr_go) begin
      wready  <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OK;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= mapped(wr_idx) ? RESP_OK : RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '0;
    end else begin
      if (wr_b0) begin
        case (wr_idx)
          IDX_IRQ_AND_LINE_CTRL: cfg.irq_and_line_ctrl <= wdata_r[7:0];
          IDX_RX_TX_ENABLE_CTRL: cfg.rx_tx_enable_ctrl <= wdata_r[7:0];
          IDX_FRAME_FORMAT_CTRL: cfg.frame_format_ctrl <= wdata_r[7:0];
          IDX_BAUD:  cfg.baud[7:0] <= wdata_r[7:0];
          IDX_DBG:   cfg.dbgrun <= wdata_r[0];
          IDX_EV:    cfg.evin <= wdata_r[0];
          IDX_TXPL:  cfg.txpl <= wdata_r[7:0];
          IDX_RXPL:  cfg.rxpl <= wdata_r[6:0];
          default:   cfg.irq_and_line_ctrl <= cfg.irq_and_line_ctrl;
        endcase
      end
      if (wr_b1 && wr_idx == IDX_BAUD) begin
        cfg.baud[15:8] <= wdata_r[15:8];
      end
    end
  end

  // ************************************************************
  // receive queue
  // ************************************************************
  always_comb begin
    new_ent.data = size_mask(rx_in.data, character_size_field); // see R12
    new_ent.frame_error_flag = !rx_in.stop1; // see R7
    new_ent.parity_error_flag = rx_in.parity_error_flag;
    new_ent.pid  = rx_in.pid;
    new_ent.ovf  = ovf_pend_r | ovf_set;
    cnt_nxt = cnt_r;
    if (!rxen) begin
      cnt_nxt = 2'h0; // see R4
    end else if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r       <= 2'h0;
      rx_in_ready <= 1'b0;
    end else begin
      cnt_r       <= cnt_nxt; // see R1
      rx_in_ready <= rxen && cnt_nxt != RXQ_DEPTH;
    end
  end

  // entry 0 is always the oldest character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r[0] <= '0;
      q_r[1] <= '0;
    end else if (pop && push) begin
      if (cnt_r == RXQ_DEPTH) begin
        q_r[0] <= q_r[1];
        q_r[1] <= new_ent;
      end else begin
        q_r[0] <= new_ent;
      end
    end else if (pop) begin
      q_r[0] <= q_r[1]; // see R2 R6
    end else if (push) begin
      if (cnt_r == 2'h0) begin
        q_r[0] <= new_ent;
      end else begin
        q_r[1] <= new_ent;
      end
    end
  end

  // overflow rides on the character that was waiting
  assign ovf_set = rxen && cnt_r == RXQ_DEPTH && rx_in_valid
                   && rx_start; // see R5

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_pend_r <= 1'b0;
    end else if (!rxen) begin
      ovf_pend_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_pend_r <= 1'b1;
    end else if (push) begin
      ovf_pend_r <= 1'b0;
    end
  end

  // ************************************************************
  // transmit holding register
  // ************************************************************
  always_comb begin
    tx_empty_nxt = tx_empty_r;
    if (tx_acc) begin
      tx_empty_nxt = 1'b0; // see R18
    end else if (tx_move) begin
      tx_empty_nxt = 1'b1; // see R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_r <= 1'b1; // see R18
      hold_r     <= RST_BYTE; // see R17
    end else begin
      tx_empty_r <= tx_empty_nxt;
      if (tx_acc) begin
        hold_r <= wdata_r[7:0]; // see R13
      end
    end
  end

  // ninth bit may land before the low byte, or after it only while the shifter stalls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_d8_r <= 1'b0; // see R17
    end else if (wr_b0 && wr_idx == IDX_TXH) begin
      tx_d8_r <= wdata_r[0]; // see R15
    end
  end

  // a pending character still leaves after the enable drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_valid <= 1'b0;
      tx_out_data  <= '0;
    end else begin
      tx_out_valid <= !tx_empty_nxt && (txen || tx_out_valid); // see R14
      tx_out_data  <= size_mask({tx_d8_r & !spi, hold_r},
                                character_size_field); // see R12 R16
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_comb begin
    rxh = 8'h00;
    if (cnt_r != 2'h0) begin
      rxh[RXC_BIT]  = 1'b1; // see R4
      rxh[OVF_BIT]  = q_r[0].ovf && !spi; // see R6 R16
      rxh[FRAME_ERROR_FLAG_BIT] = q_r[0].frame_error_flag && !spi; // see R7 R16
      rxh[PARITY_ERROR_FLAG_BIT] = q_r[0].parity_error_flag && (pen || lin)
                      && !spi; // see R8 R9
      rxh[D8_BIT]   = lin ? !q_r[0].pid : q_r[0].data[8]; // see R10 R11
    end
    rd_word = 32'h0000_0000;
    case (rd_idx)
      IDX_RXL:   rd_word[7:0] = (cnt_r != 2'h0) ? q_r[0].data[7:0]
                                                  : RST_BYTE;
      IDX_RXH:   rd_word[7:0] = rxh;
      IDX_TXL:   rd_word[7:0] = hold_r;
      IDX_STAT: begin
        rd_word[RXC_BIT] = cnt_r != 2'h0;
        rd_word[DRE_BIT] = tx_empty_r;
      end
      IDX_IRQ_AND_LINE_CTRL: rd_word[7:0]  = cfg.irq_and_line_ctrl;
      IDX_RX_TX_ENABLE_CTRL: rd_word[7:0]  = cfg.rx_tx_enable_ctrl;
      IDX_FRAME_FORMAT_CTRL: rd_word[7:0]  = cfg.frame_format_ctrl;
      IDX_BAUD:  rd_word[15:0] = cfg.baud;
      IDX_DBG:   rd_word[0]    = cfg.dbgrun;
      IDX_EV:    rd_word[0]    = cfg.evin;
      IDX_TXPL:  rd_word[7:0]  = cfg.txpl;
      IDX_RXPL:  rd_word[6:0]  = cfg.rxpl;
      default:   rd_word       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OK;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= mapped(rd_idx) ? RESP_OK : RESP_ERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_depth;
    @(posedge aclk) disable iff (!aresetn)
    cnt_r <= RXQ_DEPTH && !(cnt_r == RXQ_DEPTH && rx_in_ready);
  endproperty
  a_depth: assert property (p_depth) // see R1
    else $error("receive queue over depth");

  property p_pop;
    @(posedge aclk) disable iff (!aresetn)
    pop && !push && rxen |=> cnt_r == $past(cnt_r) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) // see R2
    else $error("low byte read did not advance queue");

  property p_flush;
    @(posedge aclk) disable iff (!aresetn)
    !rxen |=> cnt_r == 2'h0 && !rx_in_ready;
  endproperty
  a_flush: assert property (p_flush) // see R4
    else $error("queue not flushed by disable");

  property p_ovf;
    @(posedge aclk) disable iff (!aresetn)
    ovf_set |=> ovf_pend_r;
  endproperty
  a_ovf: assert property (p_ovf) // see R5
    else $error("overflow not recorded");

  property p_empty_read;
    @(posedge aclk) disable iff (!aresetn)
    rd_go && rd_idx == IDX_RXL && cnt_r == 2'h0 |=> cnt_r == 2'h0
      || $past(push);
  endproperty
  a_empty_read: assert property (p_empty_read) // see R19
    else $error("empty read changed queue");

  property p_dre_clear;
    @(posedge aclk) disable iff (!aresetn)
    tx_acc |=> !tx_empty_r && hold_r == $past(wdata_r[7:0]);
  endproperty
  a_dre_clear: assert property (p_dre_clear) // see R13 R18
    else $error("accepted write did not fill holding register");

  property p_discard;
    @(posedge aclk) disable iff (!aresetn)
    wr_b0 && wr_idx == IDX_TXL && !tx_empty_r |=> $stable(hold_r);
  endproperty
  a_discard: assert property (p_discard) // see R13
    else $error("write while full was not discarded");

  property p_move;
    @(posedge aclk) disable iff (!aresetn)
    tx_move |=> tx_empty_r && !tx_out_valid;
  endproperty
  a_move: assert property (p_move) // see R14 R18
    else $error("moved character left flag clear");

  property p_reset;
    @(posedge aclk)
    !aresetn |=> tx_empty_r && cnt_r == 2'h0 && !tx_out_valid
                 && hold_r == RST_BYTE && !tx_d8_r;
  endproperty
  a_reset: assert property (p_reset) // see R17 R18
    else $error("wrong state after reset");
endmodule : spdb_top
`default_nettype wire

// [spdb_far_model.sv]
// far-side model: receive shifter and transmit shifter of the port
`default_nettype none
module spdb_far_model
  import spdb_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // characters towards the buffers
  output spdb_rx_in_type  rx_in,
  output logic            rx_in_valid,
  input  wire logic       rx_in_ready,
  output logic            rx_start,
  // characters from the buffers
  input  wire logic [8:0] tx_out_data,
  input  wire logic       tx_out_valid,
  output logic            tx_out_ready,
  // bench control and observation
  input  wire logic       tx_stall,
  output logic [8:0]      tx_seen,
  output logic [7:0]      tx_cnt
);
  initial begin
    rx_in       = '0;
    rx_in_valid = 1'b0;
    rx_start    = 1'b0;
  end

  // shifter counts as busy while the bench stalls it
  assign tx_out_ready = !tx_stall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_seen <= 9'h000;
      tx_cnt  <= 8'h00;
    end else if (tx_out_valid && tx_out_ready) begin
      tx_seen <= tx_out_data;
      tx_cnt  <= tx_cnt + 8'h01;
    end
  end

  // offer one character; ovf pulses a new start bit while it waits
  task send(input logic [8:0] d, input logic s1, input logic pe,
            input logic pid, input logic ovf);
    @(posedge aclk);
    rx_in       <= {d, s1, pe, pid};
    rx_in_valid <= 1'b1;
    if (ovf) begin
      @(posedge aclk);
      rx_start <= 1'b1;
      @(posedge aclk);
      rx_start <= 1'b0;
    end
    do @(posedge aclk); while (!rx_in_ready);
    rx_in_valid <= 1'b0;
    // released lines do not keep the last value
    rx_in       <= ~{d, s1, pe, pid};
  endtask : send
endmodule : spdb_far_model
`default_nettype wire

// [testbench.sv]
// self-checking bench of the serial port data buffers
`default_nettype none
module testbench
  import spdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tx_stall;
  logic rx_in_valid, rx_in_ready, rx_start, tx_out_valid, tx_out_ready;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [8:0]  tx_out_data, tx_seen;
  logic [7:0]  tx_cnt;
  spdb_rx_in_type rx_in;
  int fail_count, total_checks, nt;

  spdb_top spdb_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready), .rx_start(rx_start),
    .tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .cfg());
  spdb_far_model far_i (.aclk(aclk), .aresetn(aresetn), .rx_in(rx_in),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
    .rx_start(rx_start), .tx_out_data(tx_out_data),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_stall(tx_stall), .tx_seen(tx_seen), .tx_cnt(tx_cnt));

  // ************************************************************
  // bus and compare helpers
  // ************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] rexp(input logic [3:0] i);
    return (i == 4'h9 || i == 4'hA || i == 4'hF) ? 32'(RESP_ERR) :
                                                   32'(RESP_OK);
  endfunction : rexp

  task wr(input logic [3:0] i, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= {i, 2'h0};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, rexp(i));
  endtask : wr

  task rdc(input logic [3:0] i, input logic [7:0] e);
    logic [31:0] d;
    @(posedge aclk);
    araddr  <= {i, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, rexp(i));
    chk(d, {24'h000000, e});
  endtask : rdc

  task txw(input logic [8:0] e);
    int k;
    nt++;
    for (k = 0; k < 50 && tx_cnt !== nt[7:0]; k++) @(posedge aclk);
    chk({24'h0, tx_cnt}, {24'h0, nt[7:0]});
    chk({23'h0, tx_seen}, {23'h0, e});
  endtask : txw

  task txcase(input logic [7:0] c, input logic h, input logic [7:0] l,
              input logic [8:0] e);
    wr(IDX_FRAME_FORMAT_CTRL, c);
    tx_stall <= 1'b1;
    if (c[2:0] == CH_9L) begin
      wr(IDX_TXL, l);
      wr(IDX_TXH, {7'h00, h});
    end else begin
      wr(IDX_TXH, {7'h00, h});
      wr(IDX_TXL, l);
    end
    tx_stall <= 1'b0;
    txw(e);
  endtask : txcase

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset;
    rdc(IDX_RXL, 8'h00);
    rdc(IDX_RXH, 8'h00);
    rdc(IDX_TXL, 8'h00);
    rdc(IDX_STAT, 8'h20);
    wr(4'h9, 8'h5A);
    rdc(4'h9, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_queue;
    wr(IDX_FRAME_FORMAT_CTRL, 8'h23);
    wr(IDX_RX_TX_ENABLE_CTRL, 8'h80);
    far_i.send(9'h0A5, 1'b0, 1'b0, 1'b1, 1'b0);
    far_i.send(9'h05A, 1'b1, 1'b1, 1'b1, 1'b0);
    repeat (2) @(posedge aclk);
    #1 chk({31'h0, rx_in_ready}, 32'h0);
    rdc(IDX_RXH, 8'h84);
    rdc(IDX_RXL, 8'hA5);
    rdc(IDX_RXH, 8'h82);
    rdc(IDX_RXL, 8'h5A);
    rdc(IDX_RXH, 8'h00);
    rdc(IDX_RXL, 8'h00);
    rdc(IDX_STAT, 8'h20);
    $display("test queue done");
  endtask : t_queue

  task t_ovf;
    wr(IDX_FRAME_FORMAT_CTRL, 8'h03);
    far_i.send(9'h011, 1'b0, 1'b1, 1'b0, 1'b0);
    far_i.send(9'h022, 1'b1, 1'b0, 1'b0, 1'b0);
    fork
      far_i.send(9'h033, 1'b1, 1'b0, 1'b0, 1'b1);
    join_none
    repeat (4) @(posedge aclk);
    rdc(IDX_RXH, 8'h84);
    rdc(IDX_RXH, 8'h84);
    rdc(IDX_RXL, 8'h11);
    repeat (3) @(posedge aclk);
    rdc(IDX_RXH, 8'h80);
    rdc(IDX_RXL, 8'h22);
    rdc(IDX_RXH, 8'hC0);
    rdc(IDX_RXL, 8'h33);
    far_i.send(9'h044, 1'b1, 1'b0, 1'b0, 1'b0);
    rdc(IDX_STAT, 8'hA0);
    wr(IDX_RX_TX_ENABLE_CTRL, 8'h00);
    rdc(IDX_RXH, 8'h00);
    $display("test overflow done");
  endtask : t_ovf

  task t_modes;
    wr(IDX_RX_TX_ENABLE_CTRL, 8'h80);
    wr(IDX_FRAME_FORMAT_CTRL, 8'h07);
    far_i.send(9'h1C3, 1'b1, 1'b0, 1'b0, 1'b0);
    rdc(IDX_RXH, 8'h81);
    rdc(IDX_RXL, 8'hC3);
    wr(IDX_FRAME_FORMAT_CTRL, 8'h00);
    far_i.send(9'h0FF, 1'b1, 1'b0, 1'b0, 1'b0);
    rdc(IDX_RXL, 8'h1F);
    wr(IDX_FRAME_FORMAT_CTRL, 8'h03);
    wr(IDX_RX_TX_ENABLE_CTRL, 8'h86);
    far_i.send(9'h0A0, 1'b1, 1'b1, 1'b1, 1'b0);
    far_i.send(9'h0B0, 1'b1, 1'b0, 1'b0, 1'b0);
    rdc(IDX_RXH, 8'h82);
    rdc(IDX_RXL, 8'hA0);
    rdc(IDX_RXH, 8'h81);
    rdc(IDX_RXL, 8'hB0);
    wr(IDX_RX_TX_ENABLE_CTRL, 8'h00);
    $display("test modes done");
  endtask : t_modes

  task t_tx;
    wr(IDX_FRAME_FORMAT_CTRL, 8'h03);
    wr(IDX_RX_TX_ENABLE_CTRL, 8'h40);
    tx_stall <= 1'b1;
    wr(IDX_TXL, 8'h3C);
    rdc(IDX_STAT, 8'h00);
    wr(IDX_TXL, 8'h99);
    rdc(IDX_TXL, 8'h3C);
    tx_stall <= 1'b0;
    txw(9'h03C);
    rdc(IDX_STAT, 8'h20);
    txcase(8'h06, 1'b1, 8'hAA, 9'h1AA);
    txcase(8'h07, 1'b1, 8'h55, 9'h155);
    txcase(8'h00, 1'b0, 8'hFF, 9'h01F);
    txcase(8'hC7, 1'b1, 8'h55, 9'h055);
    $display("test transmit done");
  endtask : t_tx

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    close_out;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 44'h0;
    wstrb        = 4'hF;
    tx_stall     = 1'b0;
    fail_count   = 0;
    total_checks = 0;
    nt           = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_queue;
    t_ovf;
    t_modes;
    t_tx;
    close_out;
  end
endmodule : testbench
`default_nettype wire
